// [logic/spi_port_pkg.sv]
// Purpose: Shared constants and types for the serial peripheral port
// Assumes: APB register bus with 32-bit data, mclk at 10 MHz
// Notes:   Offsets are byte addresses; all registers reset to zero except bit 0 of flags and format, which reads one
package spi_port_pkg;
  // Register byte offsets
  localparam logic [7:0] ShiftDataOff   = 8'h00;
  localparam logic [7:0] PortControlOff = 8'h04;
  localparam logic [7:0] IntFlagsOff    = 8'h08;
  localparam logic [7:0] CharFormatOff  = 8'h0c;
  localparam logic [7:0] BitRateOff     = 8'h14;
  localparam logic [7:0] DmaControlOff  = 8'h18;
  // Control field positions
  localparam int CtlIrqEn    = 7;
  localparam int CtlForce    = 6;
  localparam int CtlTimerEn  = 5;
  localparam int CtlPhase    = 4;
  localparam int CtlIdleHigh = 3;
  localparam int CtlWiredOr  = 2;
  localparam int CtlMaster   = 1;
  localparam int CtlStart    = 0;
  // Flag field positions
  localparam int FlIrq       = 7;
  localparam int FlTxOvr     = 6;
  localparam int FlCollision = 5;
  localparam int FlAbort     = 4;
  localparam int FlRxOvr     = 3;
  localparam int FlTxUnder   = 2;
  localparam int FlActive    = 1;
  localparam int FlSelected  = 0;
  // Format field positions
  localparam int FmtMsbAlign = 7;
  localparam int FmtLenLo    = 2;
  localparam int FmtSelDir   = 1;
  localparam int FmtSelVal   = 0;
  // DMA enable positions in the DMA control register
  localparam int DmaRxEn     = 31;
  localparam int DmaTxEn     = 15;
  // Reset values
  localparam logic [7:0]  CtlReset   = 8'h00;
  localparam logic [7:0]  FmtReset   = 8'h00;
  localparam logic [15:0] DataReset  = 16'h0000;
  localparam logic [15:0] RateReset  = 16'h0000;
  // Minimum legal reload value for master operation
  localparam logic [15:0] RateMin    = 16'h0002;
  // Shifter states
  typedef enum logic [2:0] {
    StIdle  = 3'b001,
    StLead  = 3'b010,
    StTrail = 3'b100
  } shift_state_t;
endpackage : spi_port_pkg

// [logic/shift_link_if.sv]
// Purpose: Carries shifter command and status between top and shifter
// Assumes: Single mclk domain
// Notes:   Control side drives cfg, shifter drives status
`timescale 1ns/100ps
`default_nettype none
interface shift_link_if;
  logic        enable;     // Port started, master or slave
  logic        master;     // Master mode
  logic        phase;      // Clock phase
  logic        idleHigh;   // Serial clock idle level
  logic [15:0] divisor;    // Half-period reload
  logic [4:0]  bitCount;   // Bits per character 1..16
  logic [15:0] txWord;     // MSB-first transmit word
  logic        txValid;    // Transmit word waiting
  logic        txTake;     // Shifter took the word
  logic [15:0] rxWord;     // Received character
  logic        rxDone;     // Character complete pulse
  logic        busy;       // Transfer in progress
  logic        abort;      // Slave abort pulse
  logic        sclkIn;     // Synchronised serial clock
  logic        selIn;      // Synchronised select, low active
  logic        dataIn;     // Synchronised data input
  logic        sclkOut;    // Serial clock drive value
  logic        dataOut;    // Serial data drive value
  modport ctl (output enable, master, phase, idleHigh, divisor, bitCount, txWord,
               txValid, sclkIn, selIn, dataIn,
               input txTake, rxWord, rxDone, busy, abort, sclkOut, dataOut);
  modport shf (input enable, master, phase, idleHigh, divisor, bitCount, txWord,
               txValid, sclkIn, selIn, dataIn,
               output txTake, rxWord, rxDone, busy, abort, sclkOut, dataOut);
endinterface : shift_link_if
`default_nettype wire

// [logic/spi_shifter.sv]
// Purpose: Character shifter for master and slave operation
// Assumes: Inputs already synchronised to mclk
// Notes:   Shifts MSB first; slave sees serial clock edges on mclk
`timescale 1ns/100ps
`default_nettype none
module spi_shifter (
  input  wire logic   mclk,  // System clock
  input  wire logic   rst_n, // Async reset, low active
  shift_link_if.shf   lnk    // Link to register block
);
  spi_port_pkg::shift_state_t stateQ, stateD;
  logic [15:0] shQ;          // Shift register
  logic [15:0] rxQ;          // Receive assembly
  logic [4:0]  cntQ;         // Bits done
  logic [15:0] divQ;         // Half-period counter
  logic        sckQ;         // Master serial clock
  logic        sckPrevQ;     // Last sampled serial clock
  logic        selPrevQ;     // Last sampled select
  logic        doneQ;        // Completion pulse
  logic        abortQ;       // Abort pulse
  logic        takeQ;        // Load pulse

  // Slave edge detection from synchronised clock
  wire slaveActive = lnk.enable && !lnk.master && !lnk.selIn;
  wire sckEdge     = lnk.sclkIn != sckPrevQ;
  wire divHit      = divQ <= 16'h0001;
  wire masterTick  = lnk.enable && lnk.master && divHit;
  wire tick        = lnk.master ? masterTick : (slaveActive && sckEdge);
  wire lastBit     = (cntQ + 5'h01) == lnk.bitCount;
  wire selStart    = !lnk.master && selPrevQ && !lnk.selIn;

  assign lnk.txTake  = takeQ;
  assign lnk.rxWord  = rxQ;
  assign lnk.rxDone  = doneQ;
  assign lnk.abort   = abortQ;
  assign lnk.busy    = stateQ != spi_port_pkg::StIdle;
  assign lnk.sclkOut = sckQ;
  assign lnk.dataOut = shQ[15];

  // Next state: lead edge samples in phase 0, trail edge in phase 1; trail edge shifts
  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      spi_port_pkg::StIdle: begin
        if (lnk.enable && lnk.txValid && (lnk.master || slaveActive)) stateD = spi_port_pkg::StLead;
      end
      spi_port_pkg::StLead: begin
        if (!lnk.enable) stateD = spi_port_pkg::StIdle;
        else if (tick) stateD = spi_port_pkg::StTrail;
      end
      spi_port_pkg::StTrail: begin
        if (!lnk.enable) stateD = spi_port_pkg::StIdle;
        else if (tick) stateD = lastBit ? spi_port_pkg::StIdle : spi_port_pkg::StLead;
      end
    endcase
    if (!lnk.master && lnk.selIn && stateQ != spi_port_pkg::StIdle) stateD = spi_port_pkg::StIdle;
  end

  // State and edge history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ   <= spi_port_pkg::StIdle;
      sckPrevQ <= 1'b0;
      selPrevQ <= 1'b1;
    end else begin
      stateQ   <= stateD;
      sckPrevQ <= lnk.sclkIn;
      selPrevQ <= lnk.selIn;
    end
  end

  // Bit rate divider, reload from divisor
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) divQ <= 16'h0000;
    else if (stateQ == spi_port_pkg::StIdle || divHit) divQ <= lnk.divisor;
    else divQ <= divQ - 16'h0001;
  end

  // Serial clock parks at idle level after each character
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) sckQ <= 1'b0;
    else if (stateQ == spi_port_pkg::StIdle) sckQ <= lnk.idleHigh;
    else if (masterTick) sckQ <= ~sckQ;
  end

  // Shift data path; phase picks sample edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shQ <= 16'h0000; rxQ <= 16'h0000; cntQ <= 5'h00;
      takeQ <= 1'b0; doneQ <= 1'b0; abortQ <= 1'b0;
    end else begin
      takeQ  <= 1'b0;
      doneQ  <= 1'b0;
      abortQ <= !lnk.master && lnk.selIn && stateQ != spi_port_pkg::StIdle
                && cntQ != 5'h00;
      if (stateQ == spi_port_pkg::StIdle && stateD == spi_port_pkg::StLead) begin
        // Phase 0 has data valid before first edge
        shQ   <= lnk.txWord;
        takeQ <= 1'b1;
        cntQ  <= 5'h00;
      end else if (selStart) begin
        cntQ <= 5'h00;
      end else if (tick && stateQ == spi_port_pkg::StLead) begin
        if (!lnk.phase) rxQ <= {rxQ[14:0], lnk.dataIn};
      end else if (tick && stateQ == spi_port_pkg::StTrail) begin
        if (lnk.phase) rxQ <= {rxQ[14:0], lnk.dataIn};
        shQ  <= {shQ[14:0], 1'b0};
        cntQ <= cntQ + 5'h01;
        doneQ <= lastBit;
      end
    end
  end
endmodule : spi_shifter
`default_nettype wire

// [logic/spi_port_control.sv]
// Purpose: APB register block and pin control of the serial port
// Assumes: mclk 10 MHz, APB slave with zero wait states
// Notes:   Functional notes follow
// Functional notes
// - Interrupt output only while enable bit set
// - DMA on suppresses data interrupt, errors stay
// - Force bit sets pending flag, may interrupt
// - Force bit cleared by zero or pending flag write
// - Timer bit runs rate timer, not while started
// - Phase picks data valid before or after edge
// - Serial clock parks at idle level bit
// - Wired-or bit makes pins open drain
// - Master bit selects master, else slave
// - Start bit runs, stop keeps configuration
// - Pending flag W1C, held by error flags
// - Transmit overrun on write to full buffer
// - Collision flag on mode fault
// - Slave abort flag on early deselect
// - Receive overrun when receive buffer full
// - Transmit underrun when buffer empty, slave only
// - Active status reads one during transfer
// - Selected status reads zero when selected
// - Alignment bit places short transmit data
// - Direction one drives select pin in master mode
// - Direction zero input, master mode only
// - Select value drives pin or reads level
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module spi_port_control (
  input  wire logic        mclk,      // System clock
  input  wire logic        rst_n,     // Async reset, low active
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB access phase
  input  wire logic        pwrite,    // APB write
  input  wire logic [7:0]  paddr,     // APB byte address
  input  wire logic [31:0] pwdata,    // APB write data
  output logic [31:0]      prdata,    // APB read data
  output logic             pready,    // APB ready
  output logic             pslverr,   // APB error
  output logic             irqOut,    // Port interrupt request
  input  wire logic        sclkIn,    // Serial clock pin level
  output logic             sclkOut,   // Serial clock drive value
  output logic             sclkOe,    // Serial clock enable
  input  wire logic        selIn,     // Select pin level, low active
  output logic             selOut,    // Select drive value
  output logic             selOe,     // Select enable
  input  wire logic        mosiIn,    // Master-out data pin level
  output logic             mosiOut,   // Master-out drive value
  output logic             mosiOe,    // Master-out enable
  input  wire logic        misoIn,    // Master-in data pin level
  output logic             misoOut,   // Master-in drive value
  output logic             misoOe     // Master-in enable
);
  shift_link_if lnk ();                 // Shifter link

  logic [7:0]  ctlQ;                    // Port control
  logic [7:0]  fmtQ;                    // Character format
  logic [15:0] txQ;                     // Transmit holding word
  logic        txFullQ;                 // Holding word valid
  logic [15:0] rxQ;                     // Receive holding word
  logic        rxFullQ;                 // Receive word unread
  logic [5:2]  errQ;                    // Error flags
  logic        txOvrQ;                  // Transmit overrun flag
  logic        irqFlagQ;                // Pending flag
  logic [15:0] rateQ;                   // Bit rate reload
  logic [31:0] dmaQ;                    // DMA enables kept
  logic [15:0] timerQ;                  // Rate timer counter
  logic [1:0]  sclkSyncQ, selSyncQ, mosiSyncQ, misoSyncQ; // Pin synchronisers
  logic        busyPrevQ;               // Last busy level
  logic [31:0] rdQ;                     // Read data register
  logic        irqQ, slvErrQ;           // Interrupt and error response
  logic [6:0]  pinQ;                    // Pin drive registers

  // APB decode
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire rd      = acc && !pwrite;
  wire wrData  = wr && paddr == spi_port_pkg::ShiftDataOff;
  wire wrCtl   = wr && paddr == spi_port_pkg::PortControlOff;
  wire wrFl    = wr && paddr == spi_port_pkg::IntFlagsOff;
  wire wrFmt   = wr && paddr == spi_port_pkg::CharFormatOff;
  wire wrRate  = wr && paddr == spi_port_pkg::BitRateOff;
  wire wrDma   = wr && paddr == spi_port_pkg::DmaControlOff;
  wire rdData  = rd && paddr == spi_port_pkg::ShiftDataOff;
  wire mapped  = paddr == spi_port_pkg::ShiftDataOff || paddr == spi_port_pkg::PortControlOff
              || paddr == spi_port_pkg::IntFlagsOff || paddr == spi_port_pkg::CharFormatOff
              || paddr == spi_port_pkg::BitRateOff  || paddr == spi_port_pkg::DmaControlOff;

  // Configuration views
  wire started  = ctlQ[spi_port_pkg::CtlStart];
  wire master   = ctlQ[spi_port_pkg::CtlMaster];
  wire wiredOr  = ctlQ[spi_port_pkg::CtlWiredOr];
  wire dmaOn    = dmaQ[spi_port_pkg::DmaRxEn] || dmaQ[spi_port_pkg::DmaTxEn];
  wire [3:0] lenField = fmtQ[5:2];
  wire [4:0] bitCount = (lenField == 4'h0) ? 5'h10 : {1'b0, lenField};
  wire [4:0] padBits  = 5'h10 - bitCount;
  wire selDrive = master && fmtQ[spi_port_pkg::FmtSelDir];
  wire timerOn  = ctlQ[spi_port_pkg::CtlTimerEn] && !started;
  wire timerHit = timerOn && timerQ <= 16'h0001;
  // MSB-aligned data already sits high; LSB-aligned data is shifted up
  wire [15:0] txAligned = fmtQ[spi_port_pkg::FmtMsbAlign] ? txQ : (txQ << padBits);
  wire [15:0] rxMasked  = rxQ & ~(16'hffff << bitCount);
  wire modeFault = started && master && !selSyncQ[1] && !selDrive;
  wire dataEvent = busyPrevQ && !lnk.busy && !txFullQ && !dmaOn;
  wire underrun  = lnk.rxDone && !txFullQ && !master;
  wire rxOverrun = lnk.rxDone && rxFullQ && !rdData;
  wire txOverrun = wrData && txFullQ && !lnk.txTake;
  // Pending flag survives a clear while any error flag is left standing
  wire irqKeep   = !(wrFl && pwdata[spi_port_pkg::FlIrq])
                || |({txOvrQ, errQ} & ~(wrFl ? pwdata[6:2] : 5'h00));
  wire errSet    = modeFault || lnk.abort || rxOverrun || underrun || txOverrun;
  wire forceSet  = wrCtl && pwdata[spi_port_pkg::CtlForce];
  wire irqSet    = errSet || dataEvent || forceSet || timerHit;

  // Shifter hookup
  assign lnk.enable   = started;
  assign lnk.master   = master;
  assign lnk.phase    = ctlQ[spi_port_pkg::CtlPhase];
  assign lnk.idleHigh = ctlQ[spi_port_pkg::CtlIdleHigh];
  assign lnk.divisor  = rateQ;
  assign lnk.bitCount = bitCount;
  assign lnk.txWord   = txAligned;
  assign lnk.txValid  = txFullQ;
  assign lnk.sclkIn   = sclkSyncQ[1];
  assign lnk.selIn    = selSyncQ[1];
  assign lnk.dataIn   = master ? misoSyncQ[1] : mosiSyncQ[1];

  spi_shifter u_shifter (
    .mclk  (mclk),
    .rst_n (rst_n),
    .lnk   (lnk)
  );

  // Two-stage pin synchronisers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclkSyncQ <= 2'b00; selSyncQ <= 2'b11; mosiSyncQ <= 2'b00; misoSyncQ <= 2'b00;
    end else begin
      sclkSyncQ <= {sclkSyncQ[0], sclkIn};
      selSyncQ  <= {selSyncQ[0], selIn};
      mosiSyncQ <= {mosiSyncQ[0], mosiIn};
      misoSyncQ <= {misoSyncQ[0], misoIn};
    end
  end

  // Control register; force bit cleared by zero or pending flag write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) ctlQ <= spi_port_pkg::CtlReset;
    else if (wrCtl) ctlQ <= pwdata[7:0];
    else if (wrFl && pwdata[spi_port_pkg::FlIrq]) ctlQ[spi_port_pkg::CtlForce] <= 1'b0;
  end

  // Format, bit rate and DMA enables
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fmtQ <= spi_port_pkg::FmtReset; rateQ <= spi_port_pkg::RateReset; dmaQ <= 32'h0000_0000;
    end else begin
      if (wrFmt) fmtQ <= pwdata[7:0] & 8'hbf;
      if (wrRate) rateQ <= pwdata[15:0];
      if (wrDma) dmaQ <= pwdata & 32'h8000_8000;
    end
  end

  // Transmit holding word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txQ <= spi_port_pkg::DataReset; txFullQ <= 1'b0;
    end else if (wrData && (!txFullQ || lnk.txTake)) begin
      txQ <= pwdata[15:0]; txFullQ <= 1'b1;
    end else if (lnk.txTake) begin
      txFullQ <= 1'b0;
    end
  end

  // Receive holding word; read empties it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxQ <= spi_port_pkg::DataReset; rxFullQ <= 1'b0;
    end else if (lnk.rxDone && (!rxFullQ || rdData)) begin
      rxQ <= lnk.rxWord; rxFullQ <= 1'b1;
    end else if (rdData) begin
      rxFullQ <= 1'b0;
    end
  end

  // Error flags: set wins over write-one clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      errQ <= 4'h0; txOvrQ <= 1'b0;
    end else begin
      txOvrQ <= txOverrun || (txOvrQ && !(wrFl && pwdata[spi_port_pkg::FlTxOvr]));
      errQ[5] <= modeFault || (errQ[5] && !(wrFl && pwdata[spi_port_pkg::FlCollision]));
      errQ[4] <= lnk.abort || (errQ[4] && !(wrFl && pwdata[spi_port_pkg::FlAbort]));
      errQ[3] <= rxOverrun || (errQ[3] && !(wrFl && pwdata[spi_port_pkg::FlRxOvr]));
      errQ[2] <= underrun || (errQ[2] && !(wrFl && pwdata[spi_port_pkg::FlTxUnder]));
    end
  end

  // Pending flag held while any error flag stays
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) irqFlagQ <= 1'b0;
    else irqFlagQ <= irqSet || (irqFlagQ && irqKeep);
  end

  // Rate timer in timer mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) timerQ <= 16'h0000;
    else if (!timerOn || timerHit) timerQ <= rateQ;
    else timerQ <= timerQ - 16'h0001;
  end

  // Read mux register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rdQ <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        spi_port_pkg::ShiftDataOff:   rdQ <= {16'h0000, rxMasked};
        spi_port_pkg::PortControlOff: rdQ <= {24'h000000, ctlQ};
        spi_port_pkg::IntFlagsOff:    rdQ <= {24'h000000, irqFlagQ, txOvrQ, errQ,
                                              lnk.busy,
                                              master ? 1'b1 : selSyncQ[1]};
        spi_port_pkg::CharFormatOff:  rdQ <= {24'h000000, fmtQ[7:1],
                                              selDrive ? fmtQ[0] : selSyncQ[1]};
        spi_port_pkg::BitRateOff:     rdQ <= {16'h0000, rateQ};
        spi_port_pkg::DmaControlOff:  rdQ <= dmaQ;
        default:                      rdQ <= 32'h0000_0000;
      endcase
    end
  end

  // Interrupt and pin registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqQ <= 1'b0; pinQ <= 7'h00; busyPrevQ <= 1'b0; slvErrQ <= 1'b0;
    end else begin
      busyPrevQ <= lnk.busy;
      slvErrQ   <= psel && !penable && !mapped;                  // Error stands in access phase
      irqQ <= ctlQ[spi_port_pkg::CtlIrqEn] && irqFlagQ;
      // Clock and master-out driven by master; open drain drives only low
      pinQ[0] <= wiredOr ? 1'b0 : lnk.sclkOut;
      pinQ[1] <= started && master && (!wiredOr || !lnk.sclkOut);
      pinQ[2] <= wiredOr ? 1'b0 : lnk.dataOut;
      pinQ[3] <= started && master && (!wiredOr || !lnk.dataOut);
      pinQ[6] <= started && !master && !selSyncQ[1] && (!wiredOr || !lnk.dataOut);
      pinQ[4] <= wiredOr ? 1'b0 : fmtQ[spi_port_pkg::FmtSelVal];
      pinQ[5] <= selDrive && (!wiredOr || !fmtQ[spi_port_pkg::FmtSelVal]);
    end
  end

  assign prdata  = rdQ;
  assign pready  = 1'b1;
  assign pslverr = slvErrQ;
  assign irqOut  = irqQ;
  assign sclkOut = pinQ[0];
  assign sclkOe  = pinQ[1];
  assign mosiOut = pinQ[2];
  assign mosiOe  = pinQ[3];
  assign misoOut = pinQ[2];
  assign misoOe  = pinQ[6];
  assign selOut  = pinQ[4];
  assign selOe   = pinQ[5];
endmodule : spi_port_control
`default_nettype wire

// [verification/spi_port_control_asserts.sv]
// Purpose: Port assertions for the serial port control
// Assumes: One mclk domain
// Notes:   Control and format are shadowed from APB writes
`timescale 1ns/100ps
`default_nettype none
module spi_port_control_asserts (
  input wire logic        mclk, rst_n, psel, penable, pwrite, // Clock, reset, APB
  input wire logic [7:0]  paddr,                              // APB address
  input wire logic [31:0] pwdata, prdata,                     // APB data
  input wire logic        irqOut, sclkOut, sclkOe, selOut,    // Pin drives
  input wire logic        selOe, mosiOut, mosiOe, misoOut     // Pin drives
);
  logic [7:0] ctlQ, fmtQ;                       // Shadow control, format
  wire logic  wrEn = psel && penable && pwrite; // Write lands
  // Shadows follow APB writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) {ctlQ, fmtQ} <= 16'h0000;
    else if (wrEn && paddr == 8'h04) ctlQ <= pwdata[7:0];
    else if (wrEn && paddr == 8'h0c) fmtQ <= pwdata[7:0];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_force; wrEn && paddr == 8'h04 && pwdata[7:6] == 2'b11; endsequence
  sequence s_steady; $past(ctlQ, 2) == ctlQ && $past(fmtQ, 2) == fmtQ; endsequence
  property p_irqGate; !ctlQ[7] && !$past(ctlQ[7]) |-> !irqOut; endproperty
  a_irqGate: assert property (p_irqGate) else $error("irq while disabled");
  property p_force; s_force |-> ##[1:3] irqOut; endproperty
  a_force: assert property (p_force) else $error("forced irq missing");
  property p_wiredOr;
    ctlQ[2] && $past(ctlQ[2]) |-> !(sclkOut || selOut || mosiOut || misoOut); endproperty
  a_wiredOr: assert property (p_wiredOr) else $error("open drain drove high");
  property p_slave; !ctlQ[1] && !$past(ctlQ[1]) |-> !mosiOe && !sclkOe; endproperty
  a_slave: assert property (p_slave) else $error("slave drove master pins");
  property p_idle; $past(ctlQ, 4) == ctlQ && ctlQ[2:0] == 3'b010 |-> sclkOut == ctlQ[3]; endproperty
  a_idle: assert property (p_idle) else $error("clock not at idle level");
  property p_rate; $changed(sclkOut) && ctlQ[1:0] == 2'b11 |-> $past(sclkOut, 2) == $past(sclkOut); endproperty
  a_rate: assert property (p_rate) else $error("serial clock too fast");
  property p_selDrive; s_steady ##0 ctlQ[2:1] == 2'b01 && fmtQ[1] |-> selOe && selOut == fmtQ[0]; endproperty
  a_selDrive: assert property (p_selDrive) else $error("select not driven");
  property p_selIn; s_steady ##0 !(ctlQ[1] && fmtQ[1]) |-> !selOe; endproperty
  a_selIn: assert property (p_selIn) else $error("select driven as input");
  property p_rsvd; psel && penable && !pwrite && paddr == 8'h04 |-> prdata[31:8] == 24'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
endmodule : spi_port_control_asserts
bind spi_port_control spi_port_control_asserts u_spi_port_control_asserts (.mclk, .rst_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .irqOut, .sclkOut, .sclkOe, .selOut,
  .selOe, .mosiOut, .mosiOe, .misoOut);
`default_nettype wire

// [verification/spi_slave_model.sv]
// Purpose: Behavioural SPI slave facing the port as master
// Assumes: Phase 0, clock idle low, 8-bit characters, MSB first
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/100ps
`default_nettype none
module spi_slave_model (
  input  wire logic       sclk,   // Serial clock from port
  input  wire logic       selN,   // Select, low active
  input  wire logic       mosi,   // Data from port
  input  wire logic [7:0] txByte, // Reply byte
  output logic            miso,   // Data to port
  output logic [7:0]      rxByte  // Last byte received
);
  logic [7:0] shQ;  // Reply shifter
  int         bitN; // Bits seen
  initial miso = 1'b1;
  // Selected: first bit valid before first edge
  always @(negedge selN) begin
    shQ = txByte;
    bitN = 0;
    miso = txByte[7];
  end
  // Sample on leading edge
  always @(posedge sclk) if (!selN) begin
    rxByte = {rxByte[6:0], mosi};
    bitN++;
  end
  // Shift on trailing edge, reload per character
  always @(negedge sclk) if (!selN) begin
    shQ = (bitN % 8 == 0) ? txByte : {shQ[6:0], 1'b0};
    miso = shQ[7];
  end
  // Deselected: line released
  always @(posedge selN) miso = ~miso;
endmodule : spi_slave_model
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the serial port control
// Assumes: Port is master at 800 ns serial clock, model is slave
// Notes:   Sent bytes kept in a queue, compared at each result
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0; // Clock, APB
  logic        pwrite = 1'b0, selDrv = 1'b1, lastErr;    // Direction, select, error
  logic [7:0]  paddr = 8'h00, slvTx, slvRx;              // Address, slave bytes
  logic [31:0] pwdata = 32'h0, prdata, rdat;             // Bus data
  logic        pready, pslverr, irqOut, sclkOut, sclkOe, selOut, selOe; // Outputs
  logic        mosiOut, mosiOe, misoOut, misoOe, misoLine;              // Outputs
  int          n_errors = 0, num_checks = 0, seed = 71787, nBits = 0;  // Counters
  logic [7:0]  expQ[$];                                  // Bytes sent
  wire logic   sclkLine = sclkOe ? sclkOut : 1'b0;       // Pulled low
  wire logic   selLine = selOe ? selOut : selDrv;        // Select level
  wire logic   mosiLine = mosiOe ? mosiOut : ~mosiOut;   // Released data
  always #50 mclk = ~mclk;
  always @(posedge sclkLine) if (!selLine) nBits++;
  spi_port_control u_spi_port_control (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irqOut, .sclkIn(sclkLine), .sclkOut, .sclkOe,
    .selIn(selLine), .selOut, .selOe, .mosiIn(mosiLine), .mosiOut, .mosiOe,
    .misoIn(misoLine), .misoOut, .misoOe);
  spi_slave_model u_spi_slave_model (.sclk(sclkLine), .selN(selLine), .mosi(mosiLine),
    .txByte(slvTx), .miso(misoLine), .rxByte(slvRx));
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdat = prdata;
    lastErr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  // Queue and write one character
  task automatic send(input logic [7:0] b, input logic msb);
    expQ.push_back(b);
    apb(1'b1, 8'h00, msb ? {16'h0, b, 8'h00} : {24'h0, b});
  endtask : send
  // Wait for all bits, then for busy low
  task automatic waitIdle;
    for (int i = 0; i < 3000 && nBits < 8 * expQ.size(); i++) @(posedge mclk);
    for (int i = 0; i < 20 && (i == 0 || rdat[1] !== 1'b0); i++) apb(1'b0, 8'h08, 32'h0);
    chk("busy", 32'h0, {31'h0, rdat[1]});
    chk("bits", 32'(8 * expQ.size()), 32'(nBits));
    chk("slave rx", {24'h0, expQ[$]}, {24'h0, slvRx});
  endtask : waitIdle
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #3000000;
    n_errors++;
    final_report();
  end
  initial begin
    slvTx = 8'($random(seed));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", (i >= 2) ? 32'h1 : 32'h0, rdat);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {rdat[30:0], lastErr});
    $display("TEST registers done");
    apb(1'b1, 8'h14, 32'h4);
    apb(1'b1, 8'h04, 32'h83);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h0c, {24'h0, i[0], 7'h22});
      send(8'($random(seed)), i[0]);
      waitIdle();
      apb(1'b0, 8'h00, 32'h0);
      chk("port rx", {24'h0, slvTx}, rdat);
      apb(1'b0, 8'h08, 32'h0);
      chk("data irq", 32'h81, {rdat[31:1] & 31'h7e, irqOut});
      apb(1'b1, 8'h08, 32'h80);
    end
    $display("TEST transfers done");
    send(8'($random(seed)), 1'b1);
    send(8'($random(seed)), 1'b1);
    apb(1'b1, 8'h00, 32'h0000_ff00);
    apb(1'b0, 8'h08, 32'h0);
    chk("overrun", 32'hc2, rdat & 32'hc2);
    apb(1'b1, 8'h08, 32'h80);
    apb(1'b0, 8'h08, 32'h0);
    chk("held irq", 32'hc0, rdat & 32'hc0);
    waitIdle();
    apb(1'b0, 8'h00, 32'h0);
    chk("port rx", {24'h0, slvTx}, rdat);
    apb(1'b1, 8'h08, 32'hfc);
    apb(1'b1, 8'h18, 32'h8000);
    send(8'($random(seed)), 1'b1);
    waitIdle();
    chk("dma irq", 32'h0, rdat & 32'hfc);
    apb(1'b1, 8'h18, 32'h0);
    $display("TEST overrun done");
    apb(1'b1, 8'h04, 32'hc3);
    apb(1'b0, 8'h08, 32'h0);
    chk("forced irq", 32'h3, {30'h0, rdat[7], irqOut});
    apb(1'b1, 8'h08, 32'h80);
    apb(1'b0, 8'h04, 32'h0);
    chk("force cleared", 32'h83, rdat);
    apb(1'b1, 8'h0c, 32'h20);
    selDrv <= 1'b0;
    repeat (2) apb(1'b0, 8'h08, 32'h0);
    chk("collision", 32'h20, rdat & 32'h20);
    selDrv <= 1'b1;
    apb(1'b1, 8'h04, 32'h0a);
    apb(1'b1, 8'h08, 32'hfc);
    apb(1'b1, 8'h04, 32'h06);
    apb(1'b1, 8'h04, 32'h00);
    $display("TEST control done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
